// file: fls_pkg.sv
// shared constants for the fast-lock serial control link, device end and host end
package fls_pkg;
  // serial word and register select
  localparam int SR_W = 24;
  localparam logic [2:0] SEL_FREQ = 3'h0;
  localparam logic [2:0] SEL_MODREF = 3'h1;
  localparam logic [2:0] SEL_PHASE = 3'h2;
  localparam logic [2:0] SEL_FUNC = 3'h3;
  localparam logic [2:0] SEL_PUMP = 3'h4;
  localparam logic [2:0] SEL_PDOWN = 3'h5;
  localparam logic [2:0] SEL_MUX = 3'h6;
  localparam logic [2:0] SEL_TEST = 3'h7;
  // field positions inside the 24-bit word
  localparam int INT_MSB = 23;
  localparam int INT_LSB = 15;
  localparam int FRAC_MSB = 14;
  localparam int FRAC_LSB = 3;
  localparam int PHASE_MSB = 14;
  localparam int PHASE_LSB = 3;
  localparam int MODREF_MSB = 23;
  localparam int MODREF_LSB = 3;
  localparam int TMR_SEL_MSB = 4;
  localparam int TMR_SEL_LSB = 3;
  localparam int TMR_CNT_MSB = 13;
  localparam int TMR_CNT_LSB = 5;
  localparam int OUT_SEL_MSB = 6;
  localparam int OUT_SEL_LSB = 3;
  localparam int LD_WIDE_BIT = 12;
  localparam logic [23:0] CTRL_RST = 24'h000000;
  // timer select codes in the charge pump word
  localparam logic [1:0] TMR_PUMP = 2'h0;
  localparam logic [1:0] TMR_SWAB = 2'h1;
  localparam logic [1:0] TMR_SWC = 2'h2;
  // fast lock figures
  localparam logic [1:0] TICK_DIV_LAST = 2'h3;
  localparam logic [6:0] CP_CELLS_MAX = 7'h40;
  localparam logic [6:0] CP_CELLS_MIN = 7'h01;
  localparam logic [6:0] CP_CELLS_LAST_STEP = 7'h02;
  // lock detect figures, errors in whole ns
  localparam logic [5:0] LOCK_CYCLES = 6'h28;
  localparam logic [7:0] ERR_TIGHT_NS = 8'h03;
  localparam logic [7:0] ERR_WIDE_NS = 8'h0A;
  localparam logic [7:0] ERR_UNLOCK_NS = 8'h1E;
  // output select codes
  localparam logic [3:0] OUT_LOW = 4'h0;
  localparam logic [3:0] OUT_HIGH = 4'h1;
  localparam logic [3:0] OUT_LOCK = 4'h2;
  localparam logic [3:0] OUT_FAST = 4'h3;
  localparam logic [3:0] OUT_TICK = 4'h4;
  // host link timing
  localparam int CLK_NS = 5;
  localparam int SCLK_HALF_NS = 40;
  localparam logic [7:0] SCLK_HALF_CYC = 8'((SCLK_HALF_NS + CLK_NS - 1) / CLK_NS);
  // host register map
  localparam logic [7:0] ADDR_CMD = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_DROP = 1;
  // host sequencer states
  typedef enum logic [2:0] {
    H_IDLE = 3'b000,
    H_LOW = 3'b001,
    H_HIGH = 3'b010,
    H_GAP = 3'b011,
    H_LOAD = 3'b100,
    H_TAIL = 3'b101
  } fls_host_state_t;
endpackage : fls_pkg

// file: fls_link_if.sv
// three-wire serial programming link between host and device
`timescale 1ns/10ps
interface fls_link_if;
  logic sclk; // serial clock, made by the host
  logic sdata; // serial data, msb first
  logic load_strobe; // rising edge latches the word
  modport host (output sclk, output sdata, output load_strobe);
  modport device (input sclk, input sdata, input load_strobe);
endinterface : fls_link_if

// file: fls_device.sv
// device end: serial shift register, control registers, fast lock and lock detect
`timescale 1ns/10ps
//
// Operation
// - timers tick at quarter of reference rate
// - new frequency starts timers, all 64 cells
// - pump expiry halves cells over six ticks
// - switches closed until own timer expires
// - host sets switch counts to pump plus seven
// - lock after 40 cycles below threshold
// - host widens threshold to 10 ns below 2 GHz
// - lock drops on new channel or above 30 ns
// - four-bit field selects multiplexed output
// - 24-bit word, msb first, rising clock edges
// - load strobe rise latches into one register
// - low three bits select destination register
// - select codes map to the eight registers
// - next reference cycle applies frequency, starts lock
// - modulus and phase wait for frequency write
module fls_device
  import fls_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  fls_link_if.device link,
  input wire logic pfd_pulse,
  input wire logic [7:0] phase_err_ns,
  output logic multiplexed_output_pin,
  output logic lock_detect,
  output logic [6:0] cp_cells,
  output logic filter_switch_a,
  output logic filter_switch_b,
  output logic filter_switch_c,
  output logic [8:0] nd_int,
  output logic [11:0] nd_frac,
  output logic [20:0] mod_ref_word,
  output logic [11:0] phase_word
);

  // pin synchronisers, bit 0 clock, bit 1 data, bit 2 load strobe
  logic [2:0] s1_reg; // first stage, read only by s2_reg
  logic [2:0] s2_reg;
  logic [2:0] s3_reg;
  logic [2:0] stable_reg; // filtered pin levels
  wire [2:0] agree = ~(s2_reg ^ s3_reg);
  wire [2:0] stable_next = (agree & s3_reg) | (~agree & stable_reg);
  wire [2:0] rise = stable_next & ~stable_reg;

  // a change only counts once two later stages agree, which rejects a one-cycle glitch
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      s1_reg <= 3'h0;
      s2_reg <= 3'h0;
      s3_reg <= 3'h0;
      stable_reg <= 3'h0;
    end else begin
      s1_reg <= {link.load_strobe, link.sdata, link.sclk};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      stable_reg <= stable_next;
    end
  end

  // input shift register
  logic [23:0] sr_reg;

  // shift one bit on each clock rise, msb arrives first
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sr_reg <= 24'h000000;
    end else if (rise[0]) begin
      sr_reg <= {sr_reg[22:0], stable_next[1]};
    end
  end

  // destination select from the three low bits
  wire select_bit_high = sr_reg[2];
  wire select_bit_mid = sr_reg[1];
  wire select_bit_low = sr_reg[0];
  wire [2:0] dest_sel = {select_bit_high, select_bit_mid, select_bit_low};
  wire load_now = rise[2];
  wire load_freq = load_now && (dest_sel == SEL_FREQ);
  wire load_pump = load_now && (dest_sel == SEL_PUMP);
  wire [1:0] pump_tmr_sel = sr_reg[TMR_SEL_MSB:TMR_SEL_LSB];
  wire [8:0] pump_tmr_val = sr_reg[TMR_CNT_MSB:TMR_CNT_LSB];

  // eight control registers, indexed by the select code
  logic [23:0] ctrl_reg [8];
  // programmed timeout counts: pump current, switches a/b, switch c
  logic [8:0] tmr_load_reg [3];

  // latch the word; a charge pump word also files its count under the chosen timer
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      for (int i = 0; i < 8; i++) begin
        ctrl_reg[i] <= CTRL_RST;
      end
      for (int i = 0; i < 3; i++) begin
        tmr_load_reg[i] <= 9'h000;
      end
    end else if (load_now) begin
      ctrl_reg[dest_sel] <= sr_reg;
      // select code 3 names no timer and only lands in the array
      if (load_pump && pump_tmr_sel != 2'h3) begin
        tmr_load_reg[pump_tmr_sel] <= pump_tmr_val;
      end
    end
  end

  // pending frequency update, applied on the next reference cycle
  logic pend_reg;
  wire apply = pend_reg && pfd_pulse;
  // a fresh frequency write in the applying cycle keeps the update pending
  wire pend_next = load_freq | (pend_reg & ~pfd_pulse);

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      pend_reg <= 1'b0;
    end else begin
      pend_reg <= pend_next;
    end
  end

  // active divider and buffered settings, all updated together
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      nd_int <= 9'h000;
      nd_frac <= 12'h000;
      mod_ref_word <= 21'h000000;
      phase_word <= 12'h000;
    end else if (apply) begin
      nd_int <= ctrl_reg[SEL_FREQ][INT_MSB:INT_LSB];
      nd_frac <= ctrl_reg[SEL_FREQ][FRAC_MSB:FRAC_LSB];
      // modulus/reference and phase sat buffered until now
      mod_ref_word <= ctrl_reg[SEL_MODREF][MODREF_MSB:MODREF_LSB];
      phase_word <= ctrl_reg[SEL_PHASE][PHASE_MSB:PHASE_LSB];
    end
  end

  // timer clock: one tick every fourth reference pulse
  logic [1:0] div_reg;
  wire tick = pfd_pulse && (div_reg == TICK_DIV_LAST);

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      div_reg <= 2'h0;
    end else if (pfd_pulse) begin
      div_reg <= div_reg + 2'h1;
    end
  end

  // timeout counters: index 0 pump, 1 switches a/b, 2 switch c
  logic [8:0] tmr_cnt_reg [3];
  logic [2:0] tmr_run_reg;
  logic [2:0] expire;
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      expire[i] = tick && tmr_run_reg[i] && (tmr_cnt_reg[i] == 9'h000);
    end
  end

  // a trigger always reloads, even mid-sequence, so a fast hop restarts cleanly
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      tmr_run_reg <= 3'h0;
      for (int i = 0; i < 3; i++) begin
        tmr_cnt_reg[i] <= 9'h000;
      end
    end else if (apply) begin
      tmr_run_reg <= 3'h7;
      for (int i = 0; i < 3; i++) begin
        tmr_cnt_reg[i] <= tmr_load_reg[i];
      end
    end else if (tick) begin
      for (int i = 0; i < 3; i++) begin
        if (expire[i]) begin
          tmr_run_reg[i] <= 1'b0;
        end else if (tmr_run_reg[i]) begin
          tmr_cnt_reg[i] <= tmr_cnt_reg[i] - 9'h001;
        end
      end
    end
  end

  // switches stay shorted while their timer runs
  assign filter_switch_a = tmr_run_reg[TMR_SWAB];
  assign filter_switch_b = tmr_run_reg[TMR_SWAB];
  assign filter_switch_c = tmr_run_reg[TMR_SWC];

  // pump cell ramp: halve each tick after pump timer expiry
  logic ramp_reg;
  logic [6:0] cells_reg;
  assign cp_cells = cells_reg;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ramp_reg <= 1'b0;
      cells_reg <= CP_CELLS_MIN;
    end else if (apply) begin
      ramp_reg <= 1'b0;
      cells_reg <= CP_CELLS_MAX;
    end else if (expire[TMR_PUMP]) begin
      ramp_reg <= 1'b1;
    end else if (tick && ramp_reg) begin
      cells_reg <= cells_reg >> 1;
      // six halvings take 64 down to one cell
      if (cells_reg == CP_CELLS_LAST_STEP) begin
        ramp_reg <= 1'b0;
      end
    end
  end

  // lock detect
  logic [5:0] lock_cnt_reg;
  logic lock_reg;
  assign lock_detect = lock_reg;
  wire wide_thr = ctrl_reg[SEL_MUX][LD_WIDE_BIT];
  wire [7:0] err_thr = wide_thr ? ERR_WIDE_NS : ERR_TIGHT_NS;
  wire err_small = phase_err_ns < err_thr;
  wire err_gross = phase_err_ns > ERR_UNLOCK_NS;
  wire [5:0] lock_cnt_inc = lock_cnt_reg + 6'h01;

  // errors between threshold and 30 ns restart the count but keep a held lock
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      lock_cnt_reg <= 6'h00;
      lock_reg <= 1'b0;
    end else if (load_freq || (pfd_pulse && err_gross)) begin
      lock_cnt_reg <= 6'h00;
      lock_reg <= 1'b0;
    end else if (pfd_pulse && err_small) begin
      if (lock_cnt_reg != LOCK_CYCLES) begin
        lock_cnt_reg <= lock_cnt_inc;
      end
      if (lock_cnt_inc == LOCK_CYCLES) begin
        lock_reg <= 1'b1;
      end
    end else if (pfd_pulse) begin
      lock_cnt_reg <= 6'h00;
    end
  end

  // output multiplexer, registered so the pin never glitches
  wire [3:0] out_sel = ctrl_reg[SEL_MUX][OUT_SEL_MSB:OUT_SEL_LSB];
  wire fast_active = (|tmr_run_reg) | ramp_reg;
  logic out_val;
  always_comb begin
    case (out_sel)
      OUT_LOW: out_val = 1'b0;
      OUT_HIGH: out_val = 1'b1;
      OUT_LOCK: out_val = lock_reg;
      OUT_FAST: out_val = fast_active;
      OUT_TICK: out_val = tick;
      default: out_val = 1'b0; // unused codes drive low
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      multiplexed_output_pin <= 1'b0;
    end else begin
      multiplexed_output_pin <= out_val;
    end
  end

endmodule : fls_device

// file: fls_host.sv
// host end: ahb-lite command registers and serial word sender
`timescale 1ns/10ps
module fls_host
  import fls_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  output logic irq,
  fls_link_if.host link
);

  // address phase capture; zero wait states, so hreadyout is held high
  logic wr_ph_reg;
  logic [7:0] addr_ph_reg;
  wire take = hsel && htrans[1] && hready;
  wire [7:0] a_lo = haddr[7:0];

  // sequencer state
  fls_host_state_t st_reg;
  logic [7:0] half_reg;
  logic [4:0] bit_reg;
  logic [23:0] word_reg;
  logic [1:0] irq_stat_reg;
  logic [1:0] irq_mask_reg;
  logic sclk_reg;
  logic sdata_reg;
  logic load_reg;

  wire busy = (st_reg != H_IDLE);
  wire wr_cmd = wr_ph_reg && (addr_ph_reg == ADDR_CMD);
  wire wr_clr = wr_ph_reg && (addr_ph_reg == ADDR_IRQ_STAT);
  wire start = wr_cmd && !busy;
  wire half_done = (half_reg == 8'h01);
  logic done_evt;
  wire [1:0] irq_set = {wr_cmd && busy, done_evt};
  wire [1:0] irq_clr = wr_clr ? hwdata[1:0] : 2'h0;

  // read mux, sampled at the address phase so data stands in the data phase
  logic [31:0] rd_val;
  always_comb begin
    case (a_lo)
      ADDR_STATUS: rd_val = {31'h00000000, busy};
      ADDR_IRQ_STAT: rd_val = {30'h00000000, irq_stat_reg};
      ADDR_IRQ_MASK: rd_val = {30'h00000000, irq_mask_reg};
      default: rd_val = 32'h00000000; // command word and unmapped read zero
    endcase
  end

  // bus slave
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      wr_ph_reg <= 1'b0;
      addr_ph_reg <= 8'h00;
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wr_ph_reg <= take && hwrite;
      addr_ph_reg <= a_lo;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (take && !hwrite) begin
        hrdata <= rd_val;
      end
    end
  end

  // interrupt status: a set in the clearing cycle wins
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      irq_stat_reg <= 2'h0;
      irq_mask_reg <= 2'h0;
      irq <= 1'b0;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
      if (wr_ph_reg && addr_ph_reg == ADDR_IRQ_MASK) begin
        irq_mask_reg <= hwdata[1:0];
      end
      irq <= |(((irq_stat_reg & ~irq_clr) | irq_set) & irq_mask_reg);
    end
  end

  // sender: data changes while the clock is low, so the device sees it settled at the rise
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st_reg <= H_IDLE;
      half_reg <= 8'h00;
      bit_reg <= 5'h00;
      word_reg <= 24'h000000;
      sclk_reg <= 1'b0;
      sdata_reg <= 1'b0;
      load_reg <= 1'b0;
      done_evt <= 1'b0;
    end else begin
      done_evt <= 1'b0;
      if (!half_done && busy) begin
        half_reg <= half_reg - 8'h01;
      end
      case (st_reg)
        H_IDLE: begin
          if (start) begin
            word_reg <= hwdata[23:0];
            sdata_reg <= hwdata[23];
            bit_reg <= 5'h00;
            half_reg <= SCLK_HALF_CYC;
            st_reg <= H_LOW;
          end
        end
        H_LOW: begin
          if (half_done) begin
            sclk_reg <= 1'b1;
            half_reg <= SCLK_HALF_CYC;
            st_reg <= H_HIGH;
          end
        end
        H_HIGH: begin
          if (half_done) begin
            sclk_reg <= 1'b0;
            half_reg <= SCLK_HALF_CYC;
            if (bit_reg == 5'h17) begin
              st_reg <= H_GAP;
            end else begin
              word_reg <= {word_reg[22:0], 1'b0};
              sdata_reg <= word_reg[22];
              bit_reg <= bit_reg + 5'h01;
              st_reg <= H_LOW;
            end
          end
        end
        H_GAP: begin
          if (half_done) begin
            load_reg <= 1'b1;
            half_reg <= SCLK_HALF_CYC;
            st_reg <= H_LOAD;
          end
        end
        H_LOAD: begin
          if (half_done) begin
            load_reg <= 1'b0;
            half_reg <= SCLK_HALF_CYC;
            st_reg <= H_TAIL;
          end
        end
        H_TAIL: begin
          if (half_done) begin
            done_evt <= 1'b1;
            st_reg <= H_IDLE;
          end
        end
        default: st_reg <= H_IDLE;
      endcase
    end
  end

  assign link.sclk = sclk_reg;
  assign link.sdata = sdata_reg;
  assign link.load_strobe = load_reg;

endmodule : fls_host

// file: fls_sva.sv
// checker on the serial link and on the device's fast lock and lock outputs
`timescale 1ns/10ps
module fls_sva
  import fls_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic sclk,
  input wire logic sdata,
  input wire logic load_strobe,
  input wire logic pfd_pulse,
  input wire logic [7:0] phase_err_ns,
  input wire logic lock_detect,
  input wire logic [6:0] cp_cells,
  input wire logic filter_switch_a,
  input wire logic filter_switch_b,
  input wire logic filter_switch_c
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // rest of an eight cycle high phase, then low
  sequence sclk_rest_s; sclk [*7] ##1 !sclk; endsequence
  sequence strobe_rest_s; load_strobe [*7] ##1 !load_strobe; endsequence
  sclk_half_a: assert property ($rose(sclk) |=> sclk_rest_s)
    else $error("serial clock high phase not eight cycles");
  data_hold_a: assert property (sclk && $past(sclk) |-> $stable(sdata))
    else $error("serial data moved while clock high");
  strobe_len_a: assert property ($rose(load_strobe) |=> strobe_rest_s)
    else $error("load strobe not eight cycles");
  strobe_quiet_a: assert property (load_strobe |-> !sclk)
    else $error("load strobe during a bit");
  // cell count moves only on a reference cycle, to full or to half
  cell_tick_a: assert property ($changed(cp_cells) |-> $past(pfd_pulse))
    else $error("pump cells moved off a reference cycle");
  cell_step_a: assert property ($changed(cp_cells) |->
    cp_cells == CP_CELLS_MAX || cp_cells == ($past(cp_cells) >> 1))
    else $error("pump cells step not full or half");
  fast_closed_a: assert property (cp_cells == CP_CELLS_MAX |->
    filter_switch_a && filter_switch_b && filter_switch_c)
    else $error("switch open at full pump current");
  switch_pair_a: assert property (filter_switch_a == filter_switch_b)
    else $error("switches a and b differ");
  close_full_a: assert property ($rose(filter_switch_c) |-> cp_cells == CP_CELLS_MAX)
    else $error("switch closed without full pump current");
  lock_drop_a: assert property (pfd_pulse && phase_err_ns > ERR_UNLOCK_NS |=> !lock_detect)
    else $error("lock kept after large error");
  lock_rise_a: assert property ($rose(lock_detect) |->
    $past(pfd_pulse) && $past(phase_err_ns) < ERR_WIDE_NS)
    else $error("lock rose without a good cycle");
endmodule : fls_sva

// file: tb.sv
// bench: host end and device end joined over the link, driven over ahb-lite
`timescale 1ns/10ps
module tb;
  import fls_pkg::*;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic pfd_pulse = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [7:0] phase_err_ns = 8'h14; // between thresholds: no lock, no drop
  logic [3:0] pfd_cnt = 4'h0;
  logic hrdy, hresp, irq, hrdy_s, hrsp_s, mux_pin, lock, sw_a, sw_b, sw_c;
  logic [6:0] cells;
  logic [8:0] nd_int, r_int;
  logic [11:0] nd_frac, ph_w, r_ph, r_fr;
  logic [20:0] mr_w, r_mr;
  logic [31:0] hrdata, hrd_s, rd_val;
  logic [53:0] ap_prev = 54'h0;
  logic [32:0] rd_q[$]; // check flag and expected read data
  logic [53:0] ap_q[$]; // expected applied settings, oldest first
  logic rd_pend = 1'b0;
  logic [3:0] m_sel [4] = '{OUT_HIGH, OUT_LOW, 4'h5, OUT_LOCK};
  logic m_exp [4] = '{1'b1, 1'b0, 1'b0, 1'b0};
  int fail_count = 0;
  int total_checks = 0;
  int n;
  wire [53:0] ap_now = {nd_int, nd_frac, mr_w, ph_w};
  fls_link_if link ();
  fls_host i_fls_host (.clk_sys(clk_sys), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hrdy),
    .hreadyout(hrdy), .hrdata(hrdata), .hresp(hresp), .irq(irq), .link(link.host));
  fls_device i_fls_device (.clk_sys(clk_sys), .sys_rst(sys_rst), .link(link.device),
    .pfd_pulse(pfd_pulse), .phase_err_ns(phase_err_ns), .multiplexed_output_pin(mux_pin),
    .lock_detect(lock), .cp_cells(cells), .filter_switch_a(sw_a), .filter_switch_b(sw_b),
    .filter_switch_c(sw_c), .nd_int(nd_int), .nd_frac(nd_frac), .mod_ref_word(mr_w),
    .phase_word(ph_w));
  fls_sva i_fls_sva (.clk_sys(clk_sys), .sys_rst(sys_rst), .sclk(link.sclk),
    .sdata(link.sdata), .load_strobe(link.load_strobe), .pfd_pulse(pfd_pulse),
    .phase_err_ns(phase_err_ns), .lock_detect(lock), .cp_cells(cells),
    .filter_switch_a(sw_a), .filter_switch_b(sw_b), .filter_switch_c(sw_c));
  initial forever #2.5 clk_sys = ~clk_sys;
  // reference cycle pulse every tenth clock
  always @(posedge clk_sys) begin
    pfd_cnt <= (pfd_cnt == 4'h9) ? 4'h0 : pfd_cnt + 4'h1;
    pfd_pulse <= (pfd_cnt == 4'h9);
  end
  // settled copies of the bus answer, away from the rising edge
  always @(negedge clk_sys) begin
    hrdy_s = hrdy;
    hrsp_s = hresp;
    hrd_s = hrdata;
  end
  // read data is compared at the edge that ends its data phase
  always @(posedge clk_sys) begin
    if (rd_pend && hrdy_s === 1'b1) begin
      if (rd_q[0][32]) cmp_val(64'(hrd_s), 64'(rd_q[0][31:0]));
      // the response code must stay okay on every read
      cmp_bit(hrsp_s, 1'b0);
      rd_q.delete(0);
    end
    rd_pend <= hsel && htrans[1] && !hwrite && hrdy_s === 1'b1;
  end
  // applied settings are compared whenever they move; a move with no note fails
  always @(negedge clk_sys) begin
    if (!sys_rst && ap_now !== ap_prev) begin
      if (ap_q.size() == 0) cmp_val(64'(ap_now), 64'(ap_prev));
      else cmp_val(64'(ap_now), 64'(ap_q.pop_front()));
    end
    ap_prev = ap_now;
  end
  task automatic cmp_val(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_val
  task automatic cmp_bit(input logic got, input logic exp);
    cmp_val({63'h0, got}, {63'h0, exp});
  endtask : cmp_bit
  // one single word transfer: address phase, then data phase
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge clk_sys);
    while (hrdy_s !== 1'b1) @(posedge clk_sys);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk_sys);
    while (hrdy_s !== 1'b1) @(posedge clk_sys);
    rd_val = hrd_s;
  endtask : ahb
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic chk);
    rd_q.push_back({chk, exp});
    ahb(1'b0, a, 32'h0);
  endtask : rd
  task automatic wait_idle();
    for (int i = 0; i < 400; i++) begin
      rd(ADDR_STATUS, 32'h0, 1'b0);
      if (rd_val[0] === 1'b0) break;
    end
    // a sender that never goes idle counts as a mismatch; later checks sit off the edge
    cmp_bit(rd_val[0], 1'b0);
    @(negedge clk_sys);
  endtask : wait_idle
  task automatic send(input logic [23:0] w);
    ahb(1'b1, ADDR_CMD, {8'h00, w});
    wait_idle();
  endtask : send
  task automatic tmr(input logic [1:0] s, input logic [8:0] c);
    send({10'h000, c, s, SEL_PUMP});
  endtask : tmr
  task automatic set_mux(input logic [3:0] s, input logic wide);
    send({11'h000, wide, 5'h00, s, SEL_MUX});
  endtask : set_mux
  task automatic freq();
    r_int = 9'($urandom);
    r_fr = 12'($urandom);
    ap_q.push_back({r_int, r_fr, r_mr, r_ph});
    send({r_int, r_fr, SEL_FREQ});
  endtask : freq
  task automatic set_err(input logic [7:0] v);
    @(posedge clk_sys);
    phase_err_ns <= v;
  endtask : set_err
  task automatic pulses(input int k);
    repeat (k) begin
      @(negedge clk_sys);
      while (pfd_pulse !== 1'b1) @(negedge clk_sys);
    end
  endtask : pulses
  // ramp from half current to one cell, then the switch opens one tick later
  task automatic ramp_end();
    for (n = 0; n < 9000 && cells !== 7'h20; n++) @(negedge clk_sys);
    for (n = 0; n < 1000 && cells !== CP_CELLS_MIN; n++) @(negedge clk_sys);
    cmp_val(64'(n), 64'h00000000000000C8);
    cmp_bit(sw_a, 1'b1);
    for (n = 0; n < 1000 && sw_a === 1'b1; n++) @(negedge clk_sys);
    cmp_val(64'(n), 64'h0000000000000028);
    cmp_bit(sw_c, 1'b0);
  endtask : ramp_end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : give_verdict
  // hang guard, well beyond the expected run
  initial begin
    #300000;
    fail_count++;
    give_verdict();
  end
  initial begin
    r_int = 9'($urandom(17));
    repeat (10) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rd(ADDR_STATUS, 32'h0, 1'b1);
    rd(8'h10, 32'h0, 1'b1);
    rd(ADDR_IRQ_MASK, 32'h0, 1'b1);
    // done flag: sticky while masked, then raises irq, then cleared by a one
    send({21'h0, SEL_TEST});
    cmp_bit(irq, 1'b0);
    rd(ADDR_IRQ_STAT, 32'h1, 1'b1);
    ahb(1'b1, ADDR_IRQ_MASK, 32'h1);
    repeat (3) @(negedge clk_sys);
    cmp_bit(irq, 1'b1);
    ahb(1'b1, ADDR_IRQ_STAT, 32'h1);
    repeat (3) @(negedge clk_sys);
    cmp_bit(irq, 1'b0);
    // a command while busy is dropped: its word must never be applied
    ahb(1'b1, ADDR_CMD, {29'h0, SEL_TEST});
    ahb(1'b1, ADDR_CMD, {8'h00, 9'h1FF, 12'hABC, SEL_FREQ});
    rd(ADDR_IRQ_STAT, 32'h2, 1'b1);
    wait_idle();
    ahb(1'b1, ADDR_IRQ_STAT, 32'h3);
    tmr(TMR_PUMP, 9'h002);
    tmr(TMR_SWAB, 9'h009);
    tmr(TMR_SWC, 9'h009);
    set_mux(OUT_LOCK, 1'b0);
    r_mr = 21'($urandom);
    r_ph = 12'($urandom);
    send({r_mr, SEL_MODREF});
    send({9'h0, r_ph, SEL_PHASE});
    freq();
    cmp_val(64'(cells), 64'(CP_CELLS_MAX));
    cmp_bit(sw_b, 1'b1);
    ramp_end();
    // lock on the fortieth good cycle, kept at 30 ns, lost at 31 ns
    pulses(1);
    set_err(8'h01);
    pulses(40);
    cmp_bit(lock, 1'b0);
    repeat (3) @(negedge clk_sys);
    cmp_bit(lock, 1'b1);
    cmp_bit(mux_pin, 1'b1);
    set_err(8'h1E);
    pulses(1);
    repeat (3) @(negedge clk_sys);
    cmp_bit(lock, 1'b1);
    set_err(8'h1F);
    pulses(1);
    repeat (3) @(negedge clk_sys);
    cmp_bit(lock, 1'b0);
    for (int i = 0; i < 4; i++) begin
      set_mux(m_sel[i], 1'b1);
      repeat (2) @(negedge clk_sys);
      cmp_bit(mux_pin, m_exp[i]);
    end
    // timer tick on the pin: one cycle high, one rise every forty clocks
    set_mux(OUT_TICK, 1'b1);
    for (n = 0; n < 100 && mux_pin !== 1'b1; n++) @(negedge clk_sys);
    @(negedge clk_sys);
    cmp_bit(mux_pin, 1'b0);
    for (n = 0; n < 100 && mux_pin !== 1'b1; n++) @(negedge clk_sys);
    cmp_val(64'(n), 64'h0000000000000027);
    // wide threshold: 5 ns now counts as good
    pulses(1);
    set_err(8'h05);
    pulses(41);
    repeat (3) @(negedge clk_sys);
    cmp_bit(lock, 1'b1);
    // longer timers, and a second channel before the first has settled
    tmr(TMR_PUMP, 9'h014);
    tmr(TMR_SWAB, 9'h01B);
    tmr(TMR_SWC, 9'h01B);
    freq();
    cmp_bit(lock, 1'b0);
    freq();
    // fast lock shows on the pin while the restarted timers run
    set_mux(OUT_FAST, 1'b1);
    repeat (2) @(negedge clk_sys);
    cmp_bit(mux_pin, 1'b1);
    repeat (200) @(negedge clk_sys);
    cmp_val(64'(cells), 64'(CP_CELLS_MAX));
    ramp_end();
    // every noted frequency word must have been applied
    cmp_val(64'(ap_q.size()), 64'h0000000000000000);
    give_verdict();
  end
endmodule : tb
